// File: common/bft_pkg.sv
// Package with modes, settings and timing constants of the breaker failure backup trip block
package bft_pkg;

  // Supervision mode encoding, reset value off
  typedef enum logic [1:0]
  {
    BFT_MODE_OFF     = 2'h0,
    BFT_MODE_CURRENT = 2'h1,
    BFT_MODE_CONTACT = 2'h2,
    BFT_MODE_BOTH    = 2'h3
  } bft_mode_t;

  // Time base
  localparam int unsigned CLK_FREQ_HZ    = 125000000;
  localparam int unsigned TICK_PERIOD_MS = 1;
  localparam int unsigned TICK_CYCLES    = (CLK_FREQ_HZ / 1000) * TICK_PERIOD_MS;
  localparam int unsigned TICK_CNT_W     = 17;

  // Setting widths
  localparam int unsigned DELAY_W = 10;
  localparam int unsigned PULSE_W = 16;
  localparam int unsigned PCT_W   = 8;
  localparam int unsigned CURR_W  = 8;

  // Setting ranges and defaults in ms and percent of rated current
  localparam logic [DELAY_W-1:0] DELAY_MIN_MS     = 10'h03c;
  localparam logic [DELAY_W-1:0] DELAY_MAX_MS     = 10'h3e8;
  localparam logic [DELAY_W-1:0] DELAY_DEF_MS     = 10'h0c8;
  localparam logic [PULSE_W-1:0] PULSE_MAX_MS     = 16'hea60;
  localparam logic [PULSE_W-1:0] PULSE_DEF_MS     = 16'h0064;
  localparam logic [PCT_W-1:0]   PH_LIMIT_MIN     = 8'h14;
  localparam logic [PCT_W-1:0]   PH_LIMIT_MAX     = 8'hc8;
  localparam logic [PCT_W-1:0]   PH_LIMIT_DEF     = 8'h1e;
  localparam logic [PCT_W-1:0]   RES_LIMIT_MIN    = 8'h0a;
  localparam logic [PCT_W-1:0]   RES_LIMIT_MAX    = 8'hc8;
  localparam logic [PCT_W-1:0]   RES_LIMIT_DEF    = 8'h14;

  // Settings carrier
  typedef struct packed
  {
    bft_mode_t          mode;
    logic [DELAY_W-1:0] delay_ms;
    logic [PULSE_W-1:0] pulse_ms;
    logic [PCT_W-1:0]   ph_limit;
    logic [PCT_W-1:0]   res_limit;
  } bft_cfg_t;

  localparam bft_cfg_t CFG_DEFAULT = '{BFT_MODE_OFF, DELAY_DEF_MS, PULSE_DEF_MS, PH_LIMIT_DEF, RES_LIMIT_DEF};

  // Measured currents, percent of rated current
  typedef struct packed
  {
    logic [CURR_W-1:0] ph_a;
    logic [CURR_W-1:0] ph_b;
    logic [CURR_W-1:0] ph_c;
    logic [CURR_W-1:0] res;
  } bft_curr_t;

endpackage

// File: rtl/bft_ms_tick.sv
// Millisecond tick generator for the breaker failure backup trip block
`timescale 1ns/1ps
module bft_ms_tick
#(
  parameter int unsigned CYCLES = bft_pkg::TICK_CYCLES
)
(
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rst_b,
  input  wire logic i_sync_clr,
  // Tick
  output logic      o_tick
);
  import bft_pkg::*;

  logic [TICK_CNT_W-1:0] cnt_q;

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cnt_q  <= '0;
      o_tick <= 1'b0;
    end
    else if (i_sync_clr)
    begin
      cnt_q  <= '0;
      o_tick <= 1'b0;
    end
    else if (cnt_q == TICK_CNT_W'(CYCLES - 1))
    begin
      cnt_q  <= '0;
      o_tick <= 1'b1;
    end
    else
    begin
      cnt_q  <= cnt_q + 1'b1;
      o_tick <= 1'b0;
    end
  end

endmodule // bft_ms_tick

// File: rtl/bft_top.sv
// Breaker failure backup trip supervision logic
//
// Behaviour
// - Backup timer starts on rising edge of the one general start input.
// - Four supervision modes: off, current, contact, combined; off after reset.
// - Current mode ignores breaker status; judges phase and residual currents only.
// - Contact mode ignores currents; judges breaker closed status only.
// - Combined mode idles only when all currents low and breaker open.
// - At timer expiry, trip if fault persists per selected mode.
// - Backup delay 60 to 1000 ms, 1 ms step, default 200 ms.
// - Trip held at least pulse length; 0 to 60000 ms, default 100.
// - Phase limit 20..200 percent default 30; residual 10..200 default 20.
// - Mode off starts no backup trip whatever the inputs; a trip pulse already running completes.
// - Block input inhibits start and timing while asserted, not a trip pulse already running; outside logic drives it.
`timescale 1ns/1ps
module bft_top
#(
  parameter int unsigned TICK_CYCLES = bft_pkg::TICK_CYCLES
)
(
  // Clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_sync_rst,
  // Settings
  input  wire bft_pkg::bft_cfg_t i_cfg,
  input  wire logic             i_cfg_load,
  // Protection inputs
  input  wire logic             i_general_start_input,
  input  wire logic             i_block,
  input  wire logic             i_breaker_closed,
  input  wire bft_pkg::bft_curr_t i_curr,
  // Outputs
  output logic                  o_backup_trip,
  output logic                  o_timer_running,
  output logic                  o_fault_present,
  output bft_pkg::bft_cfg_t     o_cfg
);
  import bft_pkg::*;

  typedef enum logic [1:0]
  {
    BFT_ST_IDLE  = 2'h0,
    BFT_ST_TIME  = 2'h1,
    BFT_ST_TRIP  = 2'h2
  } bft_state_t;

  bft_cfg_t              cfg_q;
  bft_state_t            state_q;
  logic                  start_q;
  logic                  tick;
  logic [DELAY_W-1:0]    delay_cnt_q;
  logic [PULSE_W-1:0]    pulse_cnt_q;
  logic                  curr_fault;
  logic                  cont_fault;
  logic                  fault;
  logic                  start_rise;
  logic                  inhibit;

  ////////////////////////////////////////////////////////////////////////////
  // Time base

  bft_ms_tick
  #(
    .CYCLES     (TICK_CYCLES)
  )
  u_tick
  (
    .i_sys_clk  (i_sys_clk),
    .i_rst_b    (i_rst_b),
    .i_sync_clr (i_sync_rst),
    .o_tick     (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Settings

  function automatic bft_cfg_t clamp_cfg(input bft_cfg_t c);
    bft_cfg_t r;
    r = c;
    if (c.delay_ms < DELAY_MIN_MS) r.delay_ms = DELAY_MIN_MS;
    if (c.delay_ms > DELAY_MAX_MS) r.delay_ms = DELAY_MAX_MS;
    if (c.pulse_ms > PULSE_MAX_MS) r.pulse_ms = PULSE_MAX_MS;
    if (c.ph_limit < PH_LIMIT_MIN) r.ph_limit = PH_LIMIT_MIN;
    if (c.ph_limit > PH_LIMIT_MAX) r.ph_limit = PH_LIMIT_MAX;
    if (c.res_limit < RES_LIMIT_MIN) r.res_limit = RES_LIMIT_MIN;
    if (c.res_limit > RES_LIMIT_MAX) r.res_limit = RES_LIMIT_MAX;
    return r;
  endfunction

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      cfg_q <= CFG_DEFAULT;
    else if (i_sync_rst)
      cfg_q <= CFG_DEFAULT;
    else if (i_cfg_load)
      cfg_q <= clamp_cfg(i_cfg);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault judgement

  // Any current at or above its limit
  assign curr_fault = (i_curr.ph_a >= cfg_q.ph_limit) || (i_curr.ph_b >= cfg_q.ph_limit) ||
                      (i_curr.ph_c >= cfg_q.ph_limit) || (i_curr.res >= cfg_q.res_limit);
  assign cont_fault = i_breaker_closed;

  always_comb
  begin
    case (cfg_q.mode)
      BFT_MODE_CURRENT: fault = curr_fault;
      BFT_MODE_CONTACT: fault = cont_fault;
      BFT_MODE_BOTH:    fault = curr_fault || cont_fault;
      default:          fault = 1'b0;
    endcase
  end

  // Block and mode off inhibit everything but a trip pulse already running
  assign inhibit    = i_block || (cfg_q.mode == BFT_MODE_OFF);
  assign start_rise = i_general_start_input && !start_q;

  ////////////////////////////////////////////////////////////////////////////
  // Start edge detect

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      start_q <= 1'b0;
    else if (i_sync_rst)
      start_q <= 1'b0;
    else
      start_q <= i_general_start_input;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequence

  // Delay counts whole ticks, so expiry lands within one ms early of setting
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_q     <= BFT_ST_IDLE;
      delay_cnt_q <= '0;
      pulse_cnt_q <= '0;
    end
    else if (i_sync_rst)
    begin
      state_q     <= BFT_ST_IDLE;
      delay_cnt_q <= '0;
      pulse_cnt_q <= '0;
    end
    else
    begin
      case (state_q)
        BFT_ST_IDLE:
        begin
          if (start_rise && !inhibit)
          begin
            state_q     <= BFT_ST_TIME;
            delay_cnt_q <= cfg_q.delay_ms;
          end
        end
        BFT_ST_TIME:
        begin
          // Fault gone or blocked returns to idle
          if (inhibit || !fault)
            state_q <= BFT_ST_IDLE;
          else if (tick)
          begin
            if (delay_cnt_q <= DELAY_W'(1))
            begin
              state_q     <= BFT_ST_TRIP;
              pulse_cnt_q <= cfg_q.pulse_ms;
            end
            else
              delay_cnt_q <= delay_cnt_q - 1'b1;
          end
        end
        BFT_ST_TRIP:
        begin
          // Hold for pulse length, then release
          if (tick)
          begin
            if (pulse_cnt_q == '0)
              state_q <= BFT_ST_IDLE;
            else
              pulse_cnt_q <= pulse_cnt_q - 1'b1;
          end
        end
        default: state_q <= BFT_ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_backup_trip   <= 1'b0;
      o_timer_running <= 1'b0;
      o_fault_present <= 1'b0;
      o_cfg           <= CFG_DEFAULT;
    end
    else
    begin
      o_backup_trip   <= (state_q == BFT_ST_TRIP) && !i_sync_rst;
      o_timer_running <= (state_q == BFT_ST_TIME) && !i_sync_rst;
      o_fault_present <= fault && !inhibit;
      o_cfg           <= cfg_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_off_no_trip: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (cfg_q.mode == BFT_MODE_OFF) |=> (state_q != BFT_ST_TIME && !$rose(state_q == BFT_ST_TRIP)))
    else $error("trip path active with mode off");

  chk_start_edge: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b || i_sync_rst)
    (state_q == BFT_ST_IDLE && start_rise && !inhibit) |=> (state_q == BFT_ST_TIME))
    else $error("timer not started on start edge");

  chk_no_level_start: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b || i_sync_rst)
    (state_q == BFT_ST_IDLE && !start_rise) |=> (state_q != BFT_ST_TIME))
    else $error("timer started without edge");

  chk_block_inhibit: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b || i_sync_rst)
    (i_block && state_q != BFT_ST_TRIP) |=> (state_q == BFT_ST_IDLE))
    else $error("block did not inhibit");

  chk_contact_only: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (cfg_q.mode == BFT_MODE_CONTACT) |-> (fault == i_breaker_closed))
    else $error("contact mode uses currents");

  chk_current_only: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (cfg_q.mode == BFT_MODE_CURRENT) |-> (fault == curr_fault))
    else $error("current mode uses breaker status");

  chk_combined_idle: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b || i_sync_rst)
    (state_q == BFT_ST_TIME && cfg_q.mode == BFT_MODE_BOTH && (curr_fault || cont_fault) && !i_block)
    |=> (state_q != BFT_ST_IDLE))
    else $error("combined mode left timing with a fault");

  chk_trip_output: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b || i_sync_rst)
    $rose(state_q == BFT_ST_TRIP) |=> o_backup_trip)
    else $error("trip output missing");

  chk_trip_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b || i_sync_rst)
    (state_q == BFT_ST_TRIP && pulse_cnt_q != '0) |=> (state_q == BFT_ST_TRIP))
    else $error("trip released early");

  chk_delay_range: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (cfg_q.delay_ms >= DELAY_MIN_MS) && (cfg_q.delay_ms <= DELAY_MAX_MS))
    else $error("delay setting out of range");

  chk_limit_range: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (cfg_q.ph_limit >= PH_LIMIT_MIN) && (cfg_q.res_limit >= RES_LIMIT_MIN))
    else $error("current limit out of range");

  chk_sync_reset: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    i_sync_rst |=> (state_q == BFT_ST_IDLE && cfg_q == CFG_DEFAULT && !o_backup_trip))
    else $error("synchronous reset incomplete");

  chk_running_out: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b || i_sync_rst)
    (state_q == BFT_ST_TIME && !i_sync_rst) |=> o_timer_running)
    else $error("timer running output missing");

  chk_delay_load: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b || i_sync_rst)
    (state_q == BFT_ST_IDLE && start_rise && !inhibit && !i_sync_rst) |=> (delay_cnt_q == $past(cfg_q.delay_ms)))
    else $error("delay counter not loaded from setting");

  chk_pulse_load: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b || i_sync_rst)
    $rose(state_q == BFT_ST_TRIP) |-> (pulse_cnt_q == $past(cfg_q.pulse_ms)))
    else $error("pulse counter not loaded from setting");

  chk_trip_after_timer: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b || i_sync_rst)
    $rose(o_backup_trip) |-> $past(o_timer_running))
    else $error("trip without running timer");

  chk_off_no_fault: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (cfg_q.mode == BFT_MODE_OFF) |=> !o_fault_present)
    else $error("fault flagged with mode off");

  cov_trip: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) $rose(o_backup_trip));
  cov_clear: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (state_q == BFT_ST_TIME && !fault && !inhibit));
  cov_block: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (state_q == BFT_ST_TIME && i_block));
  cov_contact_trip: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (cfg_q.mode == BFT_MODE_CONTACT && $rose(o_backup_trip)));
  cov_combined_drop: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (cfg_q.mode == BFT_MODE_BOTH && state_q == BFT_ST_TIME && !fault && !i_block));

endmodule // bft_top

// File: test/bft_far_side.sv
// Model of the outside protection logic and breaker status feeding the block
`timescale 1ns/1ps
module bft_far_side
(
  // Clock
  input  wire logic               i_sys_clk,
  // Requests from the bench
  input  wire logic               i_start_req,
  input  wire logic               i_brk_req,
  input  wire logic               i_blk_req,
  input  wire bft_pkg::bft_curr_t i_curr_req,
  // Lines into the block
  output logic                    o_start,
  output logic                    o_brk,
  output logic                    o_blk,
  output bft_pkg::bft_curr_t      o_curr
);
  import bft_pkg::*;

  // Start, breaker status and currents
  // Registered so the lines move only on the sampling edge, one cycle after the requests
  always_ff @(posedge i_sys_clk)
  begin
    o_start <= i_start_req;
    o_brk   <= i_brk_req;
    o_curr  <= i_curr_req;
  end

  always_ff @(posedge i_sys_clk)
  begin
    o_blk <= i_blk_req;
  end
endmodule // bft_far_side

// File: test/tb_top.sv
// Self-checking bench of the breaker failure backup trip block
`timescale 1ns/1ps
module tb_top;
  import bft_pkg::*;
  // Short tick keeps the run small
  localparam int unsigned TCK = 10;
  logic        clk       = 1'b0;
  logic        rst_b     = 1'b0;
  logic        sync_rst  = 1'b0;
  bft_cfg_t    cfg       = CFG_DEFAULT;
  logic        cfg_load  = 1'b0;
  logic        start_req = 1'b0;
  logic        brk_req   = 1'b0;
  logic        blk_req   = 1'b0;
  bft_curr_t   curr_req  = '0;
  logic        start;
  logic        brk;
  logic        blk;
  bft_curr_t   curr;
  logic        trip;
  logic        running;
  logic        fault_out;
  bft_cfg_t    cfg_out;
  int          err_total   = 0;
  int          check_count = 0;
  logic [15:0] rnd         = 16'h0063;

  always #4 clk = ~clk;

  bft_far_side far (.i_sys_clk(clk), .i_start_req(start_req), .i_brk_req(brk_req), .i_blk_req(blk_req),
    .i_curr_req(curr_req), .o_start(start), .o_brk(brk), .o_blk(blk), .o_curr(curr));

  bft_top #(.TICK_CYCLES(TCK)) dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_sync_rst(sync_rst), .i_cfg(cfg),
    .i_cfg_load(cfg_load), .i_general_start_input(start), .i_block(blk), .i_breaker_closed(brk),
    .i_curr(curr), .o_backup_trip(trip), .o_timer_running(running), .o_fault_present(fault_out),
    .o_cfg(cfg_out));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic exp_trip(input bft_mode_t m, input logic cf, input logic kf);
    case (m)
      BFT_MODE_CURRENT: return cf;
      BFT_MODE_CONTACT: return kf;
      BFT_MODE_BOTH:    return cf | kf;
      default:          return 1'b0;
    endcase
  endfunction

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cfg(input bft_cfg_t got, input bft_cfg_t exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic load(input bft_cfg_t c);
    @(posedge clk);
    cfg      <= c;
    cfg_load <= 1'b1;
    @(posedge clk);
    cfg_load <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // One start; drop clears faults, bk blocks, both at a fixed point mid-timing
  task automatic run(input bft_mode_t m, input logic cf, input logic kf, input logic bk, input logic dr);
    bft_curr_t cv;
    logic      seen;
    int        dly;
    int        pls;
    int        pm;
    seen = 1'b0;
    dly  = 0;
    pls  = 0;
    rnd  = lfsr(rnd);
    pm   = int'(rnd[1:0]);
    load('{m, DELAY_MIN_MS, {14'h0, rnd[1:0]}, PH_LIMIT_DEF, RES_LIMIT_DEF});
    cv.ph_a = rnd[7:0] % PH_LIMIT_DEF;
    cv.ph_b = rnd[15:8] % PH_LIMIT_DEF;
    cv.ph_c = rnd[11:4] % PH_LIMIT_DEF;
    cv.res  = rnd[13:6] % RES_LIMIT_DEF;
    // Fault exactly at the limit: the boundary counts as fault
    if (cf && rnd[2])
      cv.ph_c = PH_LIMIT_DEF;
    else if (cf)
      cv.res = RES_LIMIT_DEF;
    @(posedge clk);
    curr_req  <= cv;
    brk_req   <= kf;
    start_req <= 1'b1;
    for (int n = 0; n < 1200; n++)
    begin
      @(posedge clk);
      if (n == 200)
      begin
        blk_req <= bk;
        if (dr)
        begin
          curr_req <= '0;
          brk_req  <= 1'b0;
        end
      end
      #1;
      if (n == 5)
        chk_bit(running, exp_trip(m, cf, kf));
      if (n == 5)
        chk_bit(fault_out, exp_trip(m, cf, kf));
      if (n == 210)
        chk_bit(running, exp_trip(m, cf, kf) & ~bk & ~dr);
      if (n == 210)
        chk_bit(fault_out, exp_trip(m, cf, kf) & ~bk & ~dr);
      if (trip === 1'b1)
      begin
        seen = 1'b1;
        pls++;
      end
      else if (seen)
        break;
      else
        dly++;
    end
    chk_bit(seen, exp_trip(m, cf, kf) & ~bk & ~dr);
    if (seen)
    begin
      chk_bit(dly >= 59 * TCK && dly <= 61 * TCK + 6, 1'b1);
      chk_bit(pls >= pm * TCK && pls <= (pm + 2) * TCK + 2, 1'b1);
    end
    $display("case mode=%0d cf=%0b kf=%0b blk=%0b drop=%0b trip=%0b", m, cf, kf, bk, dr, seen);
    @(posedge clk);
    start_req <= 1'b0;
    blk_req   <= 1'b0;
    curr_req  <= '0;
    brk_req   <= 1'b0;
    repeat (20) @(posedge clk);
  endtask

  task automatic wrap_up();
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    chk_cfg(cfg_out, CFG_DEFAULT);
    chk_bit(trip, 1'b0);
    load('{BFT_MODE_BOTH, 10'h005, 16'hffff, 8'h00, 8'h00});
    chk_cfg(cfg_out, '{BFT_MODE_BOTH, DELAY_MIN_MS, PULSE_MAX_MS, PH_LIMIT_MIN, RES_LIMIT_MIN});
    load('{BFT_MODE_CURRENT, 10'h3ff, 16'h0000, 8'hff, 8'hff});
    chk_cfg(cfg_out, '{BFT_MODE_CURRENT, DELAY_MAX_MS, 16'h0000, PH_LIMIT_MAX, RES_LIMIT_MAX});
    @(posedge clk);
    sync_rst <= 1'b1;
    @(posedge clk);
    sync_rst <= 1'b0;
    @(posedge clk);
    #1;
    chk_cfg(cfg_out, CFG_DEFAULT);
    for (int m = 0; m < 4; m++)
      for (int f = 0; f < 4; f++)
        run(bft_mode_t'(m), f[0], f[1], 1'b0, 1'b0);
    run(BFT_MODE_BOTH, 1'b1, 1'b1, 1'b1, 1'b0);
    run(BFT_MODE_BOTH, 1'b1, 1'b1, 1'b0, 1'b1);
    run(BFT_MODE_CURRENT, 1'b1, 1'b0, 1'b0, 1'b1);
    wrap_up();
  end

  // Runs need about 19000 cycles
  initial
  begin
    repeat (60000) @(posedge clk);
    err_total++;
    wrap_up();
  end
endmodule // tb_top
